/* include/cpb_defines.vh */
`ifndef CPB_DEFINES_VH
`define CPB_DEFINES_VH

// special function register addresses
`define CPB_ADDR_PAGE        8'h85
`define CPB_ADDR_BANK        8'h86
`define CPB_ADDR_SYSTEM_CONFIGURATION       8'hBF
// reset values
`define CPB_RST_PAGE         8'h00
`define CPB_RST_BANK         8'h01
`define CPB_RST_SYSTEM_CONFIGURATION        8'h02
`define CPB_RST_OME          1'b1
`define CPB_RST_BANK_NUM     4'h1
// field positions
`define CPB_SYSTEM_CONFIGURATION_OME        1
`define CPB_BANK_EN          7
`define CPB_BANK_NUM_HI      3
`define CPB_PAGE_HI          1

// opcodes
`define CPB_OP_JMP_ADPTR     8'h73
`define CPB_OP_JZ            8'h60
`define CPB_OP_JNZ           8'h70
`define CPB_OP_JC            8'h40
`define CPB_OP_JNC           8'h50
`define CPB_OP_JB            8'h20
`define CPB_OP_JNB           8'h30
`define CPB_OP_JBC           8'h10
`define CPB_OP_CJNE_DIR      8'hB5
`define CPB_OP_CJNE_IMM      8'hB4
`define CPB_OP_CJNE_IND      7'h5B
`define CPB_OP_CJNE_REG      5'h17
`define CPB_OP_DJNZ_REG      5'h1B
`define CPB_OP_DJNZ_DIR      8'hD5
`define CPB_OP_ANL_BIT       8'h82
`define CPB_OP_ANL_NBIT      8'hB0
`define CPB_OP_ORL_BIT       8'h72
`define CPB_OP_ORL_NBIT      8'hA0
`define CPB_OP_MOV_C_BIT     8'hA2
`define CPB_OP_MOV_BIT_C     8'h92

// instruction lengths and cycles
`define CPB_LEN_1            2'h1
`define CPB_LEN_2            2'h2
`define CPB_LEN_3            2'h3
`define CPB_CYC_1            3'h1
`define CPB_CYC_2            3'h2

// memory map
`define CPB_PROG_TOP         16'h3FFF
`define CPB_REGS_TOP         8'h1F
`define CPB_BITS_TOP         8'h2F
`define CPB_LOW_TOP          8'h7F
`define CPB_WIN_BASE         2'h1
`define CPB_XRAM_TOP         16'h02FF
`define CPB_XRAM_DEPTH       768
`define CPB_XRAM_AW          10
`define CPB_PAGE_OFF         2'h3
`define CPB_SCRATCH_TOP      10'h0FF
`define CPB_XRAM_SHIFT       10'h100

`endif

/* rtl/cpb_rel_target.v */
`timescale 1ns/1ps
`default_nettype none
module cpb_rel_target
(
	input  wire [15:0] base,
	input  wire [1:0]  len,
	input  wire [7:0]  offset,
	output wire [15:0] target
);
	wire [15:0] follow;

	assign follow = base + {14'h0000, len};
	// offset counts from the byte after the branch
	assign target = follow + {{8{offset[7]}}, offset};
endmodule // cpb_rel_target
`default_nettype wire

/* rtl/cpb_xram.v */
`timescale 1ns/1ps
`include "cpb_defines.vh"
`default_nettype none
module cpb_xram
(
	input  wire                    core_clk,
	input  wire                    en,
	input  wire                    we,
	input  wire [`CPB_XRAM_AW-1:0] addr,
	input  wire [7:0]              wdata,
	output reg  [7:0]              rdata
);
	reg [7:0] mem [0:`CPB_XRAM_DEPTH-1];

	// no reset on contents, as a real sram
	always @(posedge core_clk)
	begin
		if (en && we)
			mem[addr] <= wdata;
		if (en && !we)
			rdata <= mem[addr];
	end
endmodule // cpb_xram
`default_nettype wire

/* rtl/cpb_core_map.v */
// Behaviour
// - 73: jump to A plus data pointer
// - 60/70: jump on A zero / nonzero
// - 40/50: jump on carry set / clear
// - 20/30/10: bit jumps, 10 clears bit
// - B5/B4: compare A, branch if unequal
// - B8-BF/B6-B7: compare immediate, branch unequal
// - D8-DF: decrement register, branch nonzero
// - D5: decrement direct byte, branch nonzero
// - 82/B0/72/A0: and/or bit into carry
// - A2 bit to carry; 92 carry to bit
// - 16KB program space from zero
// - 00h-7Fh direct and indirect
// - register, bit, general areas in low RAM
// - upper half: indirect RAM, direct SFR
// - 768 expanded bytes at 0000h-02FFh
// - expanded RAM enable bit, resets set
// - pointer moves and bank window paths
// - page select and bank control registers
// - enable clear: all moves go off-chip
// - 16-bit pointer past 768 goes off-chip
// - page bits give upper register-pointer address
// - bank window only while bank enable set
`timescale 1ns/1ps
`include "cpb_defines.vh"
`default_nettype none
module cpb_core_map
(
	input  wire        core_clk,
	input  wire        rst_n,
	// decode request
	input  wire        instr_valid,
	input  wire [7:0]  opcode,
	input  wire [7:0]  operand1,
	input  wire [7:0]  operand2,
	input  wire [15:0] pc,
	input  wire [7:0]  acc,
	input  wire        carry,
	input  wire [15:0] data_pointer16,
	input  wire        bit_value,
	input  wire [7:0]  dir_data,
	input  wire [7:0]  reg_data,
	// decode result
	output reg         dec_valid,
	output reg         dec_known,
	output reg  [1:0]  dec_len,
	output reg  [2:0]  dec_cycles,
	output reg         dec_taken,
	output reg  [15:0] dec_target,
	output reg         dec_target_ok,
	output reg         carry_we,
	output reg         carry_out,
	output reg         bit_we,
	output reg         bit_wdata,
	output reg         byte_we,
	output reg  [7:0]  byte_wdata,
	// special function register port
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_addr,
	input  wire [7:0]  sfr_wdata,
	output reg         sfr_hit,
	output reg  [7:0]  sfr_rdata,
	// internal data access
	input  wire        mem_req,
	input  wire        mem_indirect,
	input  wire        mem_we,
	input  wire [7:0]  mem_addr,
	input  wire [7:0]  mem_wdata,
	output reg         map_valid,
	output reg         map_regbank,
	output reg         map_bitarea,
	output reg         map_general,
	output reg         map_upper,
	output reg         map_sfr,
	output reg         map_window,
	output reg  [9:0]  map_phys,
	// external data move
	input  wire        xmov_req,
	input  wire        xmov_use_data_pointer16,
	input  wire        xmov_we,
	input  wire [7:0]  xmov_ri,
	input  wire [7:0]  xmov_wdata,
	output reg         ext_req,
	output reg         ext_we,
	output reg  [15:0] ext_addr,
	output reg  [7:0]  ext_wdata,
	output reg         xram_rvalid,
	output wire [7:0]  xram_rdata
);
	reg        expanded_ram_enable;
	reg        page_select_hi;
	reg        page_select_lo;
	reg        bank_window_enable;
	reg  [3:0] bank_number;

	reg        next_known;
	reg  [1:0] next_len;
	reg  [2:0] next_cycles;
	reg        next_taken;
	reg        next_rel2;
	reg        next_indirect_jump;
	reg        next_carry_we;
	reg        next_carry_out;
	reg        next_bit_we;
	reg        next_bit_wdata;
	reg        next_byte_we;
	reg  [7:0] next_byte_wdata;

	wire [7:0]  rel_offset;
	wire [15:0] rel_target;
	wire [15:0] jump_target;
	wire [7:0]  dec_reg;
	wire [7:0]  dec_dir;

	assign rel_offset = next_rel2 ? operand2 : operand1;
	assign dec_reg = reg_data - 8'h01;
	assign dec_dir = dir_data - 8'h01;
	assign jump_target = data_pointer16 + {8'h00, acc};

	cpb_rel_target u_rel
	(
		.base   (pc),
		.len    (next_len),
		.offset (rel_offset),
		.target (rel_target)
	);

	always @*
	begin
		next_known = 1'b1;
		next_len = `CPB_LEN_2;
		next_cycles = `CPB_CYC_2;
		next_taken = 1'b0;
		next_rel2 = 1'b0;
		next_indirect_jump = 1'b0;
		next_carry_we = 1'b0;
		next_carry_out = carry;
		next_bit_we = 1'b0;
		next_bit_wdata = 1'b0;
		next_byte_we = 1'b0;
		next_byte_wdata = 8'h00;
		case (opcode)
		`CPB_OP_JMP_ADPTR:
		begin
			next_len = `CPB_LEN_1;
			next_taken = 1'b1;
			next_indirect_jump = 1'b1;
		end
		`CPB_OP_JZ:
			next_taken = (acc == 8'h00);
		`CPB_OP_JNZ:
			next_taken = (acc != 8'h00);
		`CPB_OP_JC:
			next_taken = carry;
		`CPB_OP_JNC:
			next_taken = !carry;
		`CPB_OP_JB, `CPB_OP_JNB, `CPB_OP_JBC:
		begin
			next_len = `CPB_LEN_3;
			next_rel2 = 1'b1;
			next_taken = (opcode == `CPB_OP_JNB) ? !bit_value : bit_value;
			next_bit_we = (opcode == `CPB_OP_JBC) && bit_value;
		end
		`CPB_OP_CJNE_DIR, `CPB_OP_CJNE_IMM:
		begin
			next_len = `CPB_LEN_3;
			next_rel2 = 1'b1;
			next_carry_we = 1'b1;
			if (opcode == `CPB_OP_CJNE_DIR)
			begin
				next_taken = (acc != dir_data);
				next_carry_out = (acc < dir_data);
			end
			else
			begin
				next_taken = (acc != operand1);
				next_carry_out = (acc < operand1);
			end
		end
		`CPB_OP_DJNZ_DIR:
		begin
			next_len = `CPB_LEN_3;
			next_rel2 = 1'b1;
			next_byte_we = 1'b1;
			next_byte_wdata = dec_dir;
			next_taken = (dec_dir != 8'h00);
		end
		`CPB_OP_ANL_BIT:
		begin
			next_carry_we = 1'b1;
			next_carry_out = carry & bit_value;
		end
		`CPB_OP_ANL_NBIT:
		begin
			next_carry_we = 1'b1;
			next_carry_out = carry & !bit_value;
		end
		`CPB_OP_ORL_BIT:
		begin
			next_carry_we = 1'b1;
			next_carry_out = carry | bit_value;
		end
		`CPB_OP_ORL_NBIT:
		begin
			next_carry_we = 1'b1;
			next_carry_out = carry | !bit_value;
		end
		`CPB_OP_MOV_C_BIT:
		begin
			next_cycles = `CPB_CYC_1;
			next_carry_we = 1'b1;
			next_carry_out = bit_value;
		end
		`CPB_OP_MOV_BIT_C:
		begin
			next_bit_we = 1'b1;
			next_bit_wdata = carry;
		end
		default:
		begin
			if (opcode[7:1] == `CPB_OP_CJNE_IND || opcode[7:3] == `CPB_OP_CJNE_REG)
			begin
				next_len = `CPB_LEN_3;
				next_rel2 = 1'b1;
				next_carry_we = 1'b1;
				next_taken = (reg_data != operand1);
				next_carry_out = (reg_data < operand1);
			end
			else if (opcode[7:3] == `CPB_OP_DJNZ_REG)
			begin
				next_byte_we = 1'b1;
				next_byte_wdata = dec_reg;
				next_taken = (dec_reg != 8'h00);
			end
			else
			begin
				next_known = 1'b0;
				next_len = `CPB_LEN_1;
				next_cycles = `CPB_CYC_1;
			end
		end
		endcase
	end

	// decoded fields are held until the next request; dec_valid and the write enables last one cycle
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			dec_valid <= 1'b0;
			dec_known <= 1'b0;
			dec_len <= `CPB_LEN_1;
			dec_cycles <= `CPB_CYC_1;
			dec_taken <= 1'b0;
			dec_target <= 16'h0000;
			dec_target_ok <= 1'b0;
			carry_we <= 1'b0;
			carry_out <= 1'b0;
			bit_we <= 1'b0;
			bit_wdata <= 1'b0;
			byte_we <= 1'b0;
			byte_wdata <= 8'h00;
		end
		else
		begin
			dec_valid <= instr_valid;
			carry_we <= instr_valid && next_carry_we;
			bit_we <= instr_valid && next_bit_we;
			byte_we <= instr_valid && next_byte_we;
			if (instr_valid)
			begin
				dec_known <= next_known;
				dec_len <= next_len;
				dec_cycles <= next_cycles;
				dec_taken <= next_taken;
				dec_target <= next_indirect_jump ? jump_target : rel_target;
				dec_target_ok <= next_indirect_jump ? (jump_target <= `CPB_PROG_TOP) :
					(rel_target <= `CPB_PROG_TOP);
				carry_out <= next_carry_out;
				bit_wdata <= next_bit_wdata;
				byte_wdata <= next_byte_wdata;
			end
		end
	end

	// configuration registers
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			expanded_ram_enable <= `CPB_RST_OME;
			page_select_hi <= 1'b0;
			page_select_lo <= 1'b0;
			bank_window_enable <= 1'b0;
			bank_number <= `CPB_RST_BANK_NUM;
			sfr_hit <= 1'b0;
			sfr_rdata <= 8'h00;
		end
		else
		begin
			if (sfr_wr)
			begin
				if (sfr_addr == `CPB_ADDR_SYSTEM_CONFIGURATION)
					expanded_ram_enable <= sfr_wdata[`CPB_SYSTEM_CONFIGURATION_OME];
				else if (sfr_addr == `CPB_ADDR_PAGE)
				begin
					page_select_hi <= sfr_wdata[`CPB_PAGE_HI];
					page_select_lo <= sfr_wdata[`CPB_PAGE_HI-1];
				end
				else if (sfr_addr == `CPB_ADDR_BANK)
				begin
					bank_window_enable <= sfr_wdata[`CPB_BANK_EN];
					bank_number <= sfr_wdata[`CPB_BANK_NUM_HI:0];
				end
			end
			sfr_hit <= (sfr_rd || sfr_wr) && (sfr_addr == `CPB_ADDR_SYSTEM_CONFIGURATION ||
				sfr_addr == `CPB_ADDR_PAGE || sfr_addr == `CPB_ADDR_BANK);
			// unused bits read as zero
			if (sfr_rd && sfr_addr == `CPB_ADDR_SYSTEM_CONFIGURATION)
				sfr_rdata <= {6'h00, expanded_ram_enable, 1'b0};
			else if (sfr_rd && sfr_addr == `CPB_ADDR_PAGE)
				sfr_rdata <= {6'h00, page_select_hi, page_select_lo};
			else if (sfr_rd && sfr_addr == `CPB_ADDR_BANK)
				sfr_rdata <= {bank_window_enable, 3'h0, bank_number};
			else
				sfr_rdata <= 8'h00;
		end
	end

	// internal data map and bank window
	wire       mem_upper;
	wire       win_hit;
	wire [9:0] win_phys;
	wire       win_xram;

	assign mem_upper = (mem_addr > `CPB_LOW_TOP);
	assign win_hit = !mem_indirect && bank_window_enable &&
		(mem_addr[7:6] == `CPB_WIN_BASE);
	assign win_phys = {bank_number, mem_addr[5:0]};
	assign win_xram = win_hit && (win_phys > `CPB_SCRATCH_TOP);

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			map_valid <= 1'b0;
			map_regbank <= 1'b0;
			map_bitarea <= 1'b0;
			map_general <= 1'b0;
			map_upper <= 1'b0;
			map_sfr <= 1'b0;
			map_window <= 1'b0;
			map_phys <= 10'h000;
		end
		else
		begin
			map_valid <= mem_req;
			if (mem_req)
			begin
				map_regbank <= !win_hit && mem_addr <= `CPB_REGS_TOP;
				map_bitarea <= !win_hit && mem_addr > `CPB_REGS_TOP &&
					mem_addr <= `CPB_BITS_TOP;
				map_general <= !win_hit && mem_addr > `CPB_BITS_TOP && !mem_upper;
				map_upper <= mem_upper && mem_indirect;
				map_sfr <= mem_upper && !mem_indirect;
				map_window <= win_hit;
				map_phys <= win_hit ? win_phys : {2'h0, mem_addr};
			end
		end
	end

	// external data moves
	wire [15:0] xmov_addr;
	wire        xmov_onchip;
	wire        xram_en;
	wire        xram_we;
	wire [9:0]  xram_addr;
	wire [7:0]  xram_wdata;
	wire [9:0]  win_xaddr;

	assign xmov_addr = xmov_use_data_pointer16 ? data_pointer16 :
		{6'h00, page_select_hi, page_select_lo, xmov_ri};
	// page three lies past the array, so it falls off-chip
	assign xmov_onchip = expanded_ram_enable && (xmov_addr <= `CPB_XRAM_TOP);
	assign win_xaddr = win_phys - `CPB_XRAM_SHIFT;
	// an on-chip move wins the array port; a window access in the same cycle is dropped
	assign xram_en = (xmov_req && xmov_onchip) || (mem_req && win_xram);
	assign xram_we = (xmov_req && xmov_onchip) ? xmov_we : mem_we;
	assign xram_addr = (xmov_req && xmov_onchip) ? xmov_addr[9:0] : win_xaddr;
	assign xram_wdata = (xmov_req && xmov_onchip) ? xmov_wdata : mem_wdata;

	cpb_xram u_xram
	(
		.core_clk (core_clk),
		.en       (xram_en),
		.we       (xram_we),
		.addr     (xram_addr),
		.wdata    (xram_wdata),
		.rdata    (xram_rdata)
	);

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ext_req <= 1'b0;
			ext_we <= 1'b0;
			ext_addr <= 16'h0000;
			ext_wdata <= 8'h00;
			xram_rvalid <= 1'b0;
		end
		else
		begin
			ext_req <= xmov_req && !xmov_onchip;
			xram_rvalid <= xram_en && !xram_we;
			if (xmov_req && !xmov_onchip)
			begin
				ext_we <= xmov_we;
				ext_addr <= xmov_addr;
				ext_wdata <= xmov_wdata;
			end
		end
	end
endmodule // cpb_core_map
`default_nettype wire

/* bench/cpb_core_map_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cpb_core_map_sva
(
	input wire        core_clk,
	input wire        rst_n,
	input wire        instr_valid,
	input wire [7:0]  opcode,
	input wire [7:0]  operand1,
	input wire [15:0] pc,
	input wire [7:0]  acc,
	input wire        carry,
	input wire [15:0] data_pointer16,
	input wire [7:0]  reg_data,
	input wire        dec_valid,
	input wire        dec_taken,
	input wire [1:0]  dec_len,
	input wire [15:0] dec_target,
	input wire        bit_we,
	input wire        bit_wdata,
	input wire [7:0]  byte_wdata,
	input wire        sfr_rd,
	input wire [7:0]  sfr_addr,
	input wire        sfr_hit,
	input wire [7:0]  sfr_rdata,
	input wire        mem_req,
	input wire        mem_indirect,
	input wire [7:0]  mem_addr,
	input wire        map_valid,
	input wire        map_upper,
	input wire        map_sfr,
	input wire        xmov_req,
	input wire        xmov_use_data_pointer16,
	input wire        ext_req,
	input wire [15:0] ext_addr
);
	reg [15:0] rel_exp;

	// captured every edge, only read the cycle after a request
	always @(posedge core_clk)
		rel_exp <= pc + 16'h0002 + {{8{operand1[7]}}, operand1};

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	jz_taken_a: assert property (instr_valid && opcode == 8'h60 |=>
		dec_valid && dec_taken == ($past(acc) == 8'h00) && dec_len == 2'h2)
		else $error("zero jump decode wrong");
	ind_jump_a: assert property (instr_valid && opcode == 8'h73 |=>
		dec_target == $past(acc) + $past(data_pointer16) && dec_len == 2'h1)
		else $error("indirect jump target wrong");
	rel_target_a: assert property (instr_valid && opcode == 8'h60 |=>
		dec_target == rel_exp)
		else $error("relative target wrong");
	djnz_reg_a: assert property (instr_valid && opcode[7:3] == 5'h1B |=>
		byte_wdata == $past(reg_data) - 8'h01 && dec_taken == ($past(reg_data) != 8'h01))
		else $error("register loop decode wrong");
	bit_store_a: assert property (instr_valid && opcode == 8'h92 |=>
		bit_we && bit_wdata == $past(carry))
		else $error("carry to bit wrong");
	sfr_miss_a: assert property (sfr_rd && !(sfr_addr inside {8'h85, 8'h86, 8'hBF}) |=>
		!sfr_hit && sfr_rdata == 8'h00)
		else $error("unmapped register answered");
	upper_split_a: assert property (mem_req && mem_addr[7] |=> map_valid &&
		map_upper == $past(mem_indirect) && map_sfr != $past(mem_indirect))
		else $error("upper half routing wrong");
	xmov_far_a: assert property (xmov_req && xmov_use_data_pointer16 && data_pointer16 > 16'h02FF |=>
		ext_req && ext_addr == $past(data_pointer16))
		else $error("pointer move past range stayed on chip");

	cover property (dec_valid && dec_taken);
	cover property (ext_req);
	cover property (sfr_hit);
endmodule // cpb_core_map_sva

bind cpb_core_map cpb_core_map_sva u_sva (.*);
`default_nettype wire

/* bench/cpb_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module cpb_ext_mem
(
	input  wire        core_clk,
	input  wire        ext_req,
	input  wire        ext_we,
	input  wire [15:0] ext_addr,
	input  wire [7:0]  ext_wdata,
	output reg  [15:0] far_addr,
	output reg  [7:0]  far_data
);
	initial
	begin
		far_addr = 16'h0000;
		far_data = 8'h00;
	end

	// off-chip store only sees what the device sends out
	always @(posedge core_clk)
		if (ext_req && ext_we)
		begin
			far_addr <= ext_addr;
			far_data <= ext_wdata;
		end
endmodule // cpb_ext_mem
`default_nettype wire

/* bench/cpb_core_map_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cpb_core_map_bench;
	reg         core_clk, rst_n, instr_valid, carry, bit_value, sfr_wr, sfr_rd;
	reg         mem_req, mem_indirect, mem_we, xmov_req, xmov_use_data_pointer16, xmov_we;
	reg  [7:0]  opcode, operand1, operand2, acc, dir_data, reg_data, sfr_addr;
	reg  [7:0]  sfr_wdata, mem_addr, mem_wdata, xmov_ri, xmov_wdata;
	reg  [15:0] pc, data_pointer16;
	wire        dec_valid, dec_known, dec_taken, dec_target_ok, carry_we, carry_out;
	wire        bit_we, bit_wdata, byte_we, sfr_hit, map_valid, map_regbank, map_bitarea;
	wire        map_general, map_upper, map_sfr, map_window, ext_req, ext_we, xram_rvalid;
	wire [1:0]  dec_len;
	wire [2:0]  dec_cycles;
	wire [7:0]  byte_wdata, sfr_rdata, ext_wdata, xram_rdata, far_data;
	wire [9:0]  map_phys;
	wire [15:0] dec_target, ext_addr, far_addr;
	integer     bad_count, compares, cyc, i;
	reg  [43:0] tv [0:23];
	reg  [43:0] r;
	reg  [15:0] et;

	cpb_core_map dut (.*);
	cpb_ext_mem far (.*);

	always #12.5 core_clk = ~core_clk;

	task test_done;
	begin
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	task chk(input [16:0] g, input [16:0] e);
	begin
		compares = compares + 1;
		if (g !== e)
		begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	end
	endtask

	task sfr(input w, input [7:0] a, input [7:0] d);
	begin
		@(negedge core_clk);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge core_clk);
		sfr_wr = 0;
		sfr_rd = 0;
		if (!w)
			chk({sfr_hit, sfr_rdata}, {a == 8'h85 || a == 8'h86 || a == 8'hBF, d});
	end
	endtask

	task mem(input ind, input [7:0] a, input [6:0] e);
	begin
		@(negedge core_clk);
		mem_req = 1;
		mem_indirect = ind;
		mem_addr = a;
		@(negedge core_clk);
		mem_req = 0;
		chk({map_valid, map_regbank, map_bitarea, map_general, map_upper, map_sfr, map_window}, e);
	end
	endtask

	task xm(input dp, input we, input [15:0] a, input [7:0] d, input [1:0] e);
	begin
		@(negedge core_clk);
		xmov_req = 1;
		xmov_use_data_pointer16 = dp;
		xmov_we = we;
		data_pointer16 = dp ? a : 16'hFFFF;
		xmov_ri = a[7:0];
		xmov_wdata = d;
		@(negedge core_clk);
		xmov_req = 0;
		chk({ext_req, xram_rvalid}, e);
		if (e[1])
			chk(ext_addr, a);
		if (e[0])
			chk(xram_rdata, d);
	end
	endtask

	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			bad_count = bad_count + 1;
			test_done;
		end
	end

	initial
	begin
		core_clk = 0;
		rst_n = 0;
		{instr_valid, carry, bit_value, sfr_wr, sfr_rd, mem_req, mem_indirect, mem_we,
			xmov_req, xmov_use_data_pointer16, xmov_we, opcode, operand1, operand2, acc, dir_data,
			reg_data, sfr_addr, sfr_wdata, mem_addr, mem_wdata, xmov_ri, xmov_wdata} = 0;
		pc = 16'h1000;
		data_pointer16 = 16'h3FF0;
		bad_count = 0;
		compares = 0;
		cyc = 0;
		// op, offset, acc, byte, {branch,carry,bit,taken}, length, cycles
		tv[0] = 44'h73_10_20_00_0_1_2;
		tv[1] = 44'h60_05_00_00_9_2_2;
		tv[2] = 44'h70_05_00_00_8_2_2;
		tv[3] = 44'h70_F0_03_00_9_2_2;
		tv[4] = 44'h40_05_00_00_D_2_2;
		tv[5] = 44'h50_05_00_00_C_2_2;
		tv[6] = 44'h20_05_00_00_B_3_2;
		tv[7] = 44'h30_05_00_00_A_3_2;
		tv[8] = 44'h10_05_00_00_B_3_2;
		tv[9] = 44'h10_05_00_00_8_3_2;
		tv[10] = 44'hB5_05_07_07_8_3_2;
		tv[11] = 44'hB4_05_07_00_9_3_2;
		tv[12] = 44'hB8_05_00_05_8_3_2;
		tv[13] = 44'hB7_05_00_06_9_3_2;
		tv[14] = 44'hD8_05_00_01_8_2_2;
		tv[15] = 44'hDF_05_00_00_9_2_2;
		tv[16] = 44'hD5_05_00_02_9_3_2;
		tv[17] = 44'hB0_05_00_00_4_2_2;
		tv[18] = 44'h82_05_00_00_6_2_2;
		tv[19] = 44'h72_05_00_00_0_2_2;
		tv[20] = 44'hA0_05_00_00_0_2_2;
		tv[21] = 44'hA2_05_00_00_2_2_1;
		tv[22] = 44'h92_05_00_00_4_2_2;
		tv[23] = 44'hA5_05_00_00_0_1_1;
		repeat (5) @(negedge core_clk);
		rst_n = 1;
		sfr(0, 8'h85, 8'h00);
		sfr(0, 8'h86, 8'h01);
		sfr(0, 8'hBF, 8'h02);
		sfr(0, 8'h84, 8'h00);
		// back to back requests: answer of one checked as the next is offered
		for (i = 0; i <= 24; i = i + 1)
		begin
			@(negedge core_clk);
			if (i > 0)
			begin
				r = tv[i-1];
				et = (r[43:36] == 8'h73) ? 16'h3FF0 + r[27:20]
					: 16'h1000 + r[7:4] + {{8{r[35]}}, r[35:28]};
				chk({dec_valid, dec_known, dec_len, dec_cycles},
					{1'b1, r[43:36] != 8'hA5, r[5:4], r[2:0]});
				if (r[8] || r[43:36] == 8'h73)
					chk({dec_target_ok, dec_target}, {et <= 16'h3FFF, et});
				if (r[11])
					chk(dec_taken, r[8]);
				if (r[43:36] == 8'h10)
					chk({bit_we, bit_we & bit_wdata}, {r[9], 1'b0});
				if (r[43:36] == 8'hD5 || r[43:39] == 5'h1B)
					chk({byte_we, byte_wdata}, {1'b1, r[19:12] - 8'h01});
				case (r[43:36])
					8'h82: chk({carry_we, carry_out}, {1'b1, r[10] & r[9]});
					8'hB0: chk({carry_we, carry_out}, {1'b1, r[10] & ~r[9]});
					8'h72: chk({carry_we, carry_out}, {1'b1, r[10] | r[9]});
					8'hA0: chk({carry_we, carry_out}, {1'b1, r[10] | ~r[9]});
					8'hA2: chk({carry_we, carry_out}, {1'b1, r[9]});
					8'h92: chk({bit_we, bit_wdata}, {1'b1, r[10]});
					default: ;
				endcase
			end
			if (i < 24)
			begin
				r = tv[i];
				instr_valid = 1;
				{opcode, operand1, operand2, acc} = {r[43:28], r[35:20]};
				{dir_data, reg_data, carry, bit_value} = {r[19:12], r[19:12], r[10:9]};
			end
			else
				instr_valid = 0;
		end
		sfr(1, 8'h86, 8'h88);
		sfr(0, 8'h86, 8'h88);
		sfr(1, 8'h85, 8'hFF);
		sfr(0, 8'h85, 8'h03);
		sfr(1, 8'hBF, 8'hFF);
		sfr(0, 8'hBF, 8'h02);
		mem(0, 8'h41, 7'h41);
		chk(map_phys, 10'h201);
		mem(0, 8'h10, 7'h60);
		mem(1, 8'h25, 7'h50);
		mem(0, 8'h35, 7'h48);
		mem(1, 8'h90, 7'h44);
		mem(0, 8'h90, 7'h42);
		mem(1, 8'h41, 7'h48);
		sfr(1, 8'h86, 8'h08);
		mem(0, 8'h41, 7'h48);
		xm(1, 1, 16'h0100, 8'h5A, 2'b00);
		xm(1, 0, 16'h0100, 8'h5A, 2'b01);
		xm(1, 1, 16'h02FF, 8'hC3, 2'b00);
		xm(1, 0, 16'h02FF, 8'hC3, 2'b01);
		xm(1, 1, 16'h0300, 8'h11, 2'b10);
		@(negedge core_clk);
		chk({far_data, far_addr}, {8'h11, 16'h0300});
		xm(0, 1, 16'h0310, 8'h22, 2'b10);
		sfr(1, 8'h85, 8'h02);
		xm(0, 1, 16'h0210, 8'hA5, 2'b00);
		xm(1, 0, 16'h0210, 8'hA5, 2'b01);
		sfr(1, 8'hBF, 8'h00);
		sfr(0, 8'hBF, 8'h00);
		xm(1, 1, 16'h0100, 8'h33, 2'b10);
		test_done;
	end
endmodule // cpb_core_map_bench
`default_nettype wire
